/* File: adcrm_pkg.sv */
// Constants for the combined read mode converter host controller
package adcrm_pkg;
   localparam int unsigned CLK_PERIOD_PS   = 5000;
   localparam int unsigned DATA_W          = 10;
   localparam int unsigned CHAN_W          = 2;
   // Typical done delay after strobe falls; four times it sets the timeout bound
   localparam int unsigned DONE_TYP_NS     = 850;
   localparam int unsigned DONE_WAIT_CYC   = 4 * ((DONE_TYP_NS * 1000) / CLK_PERIOD_PS);
   // Least settle time from done to valid data
   localparam int unsigned DATA_SETTLE_NS  = 20;
   localparam int unsigned DATA_SETTLE_CYC = ((DATA_SETTLE_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Setup of select lines and chip select before the strobe falls
   localparam int unsigned SETUP_NS        = 10;
   localparam int unsigned SETUP_CYC       = ((SETUP_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W           = 12;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE    = 12'h001;
   localparam logic [CNT_W-1:0] WAIT_MAX   = CNT_W'(DONE_WAIT_CYC);
   localparam logic [CNT_W-1:0] SETTLE_MAX = CNT_W'(DATA_SETTLE_CYC);
   localparam logic [CNT_W-1:0] SETUP_MAX  = CNT_W'(SETUP_CYC);
   localparam logic [DATA_W-1:0] DATA_RST  = 10'h000;
   localparam logic [CHAN_W-1:0] CHAN_RST  = 2'h0;
   localparam logic [2:0]        SYNC_IDLE = 3'h7;
   typedef enum logic [2:0] {
      ADCRM_IDLE,
      ADCRM_SETUP,
      ADCRM_WAIT,
      ADCRM_SETTLE,
      ADCRM_END
   } adcrm_state_t;
endpackage

/* File: adcrm_host.sv */
// Host controller driving the converter in combined read mode
`timescale 1ns/1ps
// Overview of operation
// - Host drives sample/hold and read strobes as one joined signal.
// - Host starts conversion by driving the joined strobe low.
// - Result valid about 20 ns after done; host waits before capture.
// - Host may time strobe to align with its sampling rate.
module adcrm_host
   import adcrm_pkg::*;
(
   input  wire logic              CLK_SYS_I,
   input  wire logic              RST_N_I,
   input  wire logic              START_I,
   input  wire logic [CHAN_W-1:0] CHANNEL_I,
   input  wire logic              DONE_N_I,
   input  wire logic [DATA_W-1:0] RESULT_BUS_I,
   output logic                   CS_N_O,
   output logic                   STROBE_N_O,
   output logic                   CHANNEL_SELECT_BIT0_O,
   output logic                   CHANNEL_SELECT_BIT1_O,
   output logic                   BUSY_O,
   output logic                   RESULT_VALID_O,
   output logic                   TIMEOUT_O,
   output logic [DATA_W-1:0]      RESULT_O
);

   adcrm_state_t      state_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [2:0]        done_sync_q;
   logic              done_low_q;
   logic [DATA_W-1:0] bus_s1_q;
   logic [DATA_W-1:0] bus_s2_q;
   logic [DATA_W-1:0] bus_s3_q;

   // Conditions decoded once; take and settle_done are shared by the pins and the state machine
   logic              bus_agree;
   logic              take;
   logic              setup_done;
   logic              wait_expired;
   logic              settle_done;

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         done_sync_q <= SYNC_IDLE;
      else
         done_sync_q <= {done_sync_q[1:0], DONE_N_I};
   end

   // Level changes only once stages two and three agree, so a glitch shorter than one cycle never counts
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         done_low_q <= 1'b0;
      else if (done_sync_q[1] == done_sync_q[2])
         done_low_q <= !done_sync_q[2];
   end

   // Bus passes three stages; a word still moving between stages two and three is not taken before the wait limit
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         bus_s1_q <= DATA_RST;
         bus_s2_q <= DATA_RST;
         bus_s3_q <= DATA_RST;
      end
      else
      begin
         bus_s1_q <= RESULT_BUS_I;
         bus_s2_q <= bus_s1_q;
         bus_s3_q <= bus_s2_q;
      end
   end

   // Cycle conditions; take and settle_done feed the state machine and the pins, setup_done and wait_expired only the pins
   assign bus_agree    = (bus_s2_q == bus_s3_q);
   assign take         = (state_q == ADCRM_IDLE) && START_I && !done_low_q;
   assign setup_done   = (state_q == ADCRM_SETUP) && (cnt_q >= SETUP_MAX);
   assign wait_expired = (state_q == ADCRM_WAIT) && !done_low_q && (cnt_q >= WAIT_MAX);
   // A bus that never settles is taken anyway once the wait limit runs out
   assign settle_done  = (state_q == ADCRM_SETTLE) && (cnt_q >= SETTLE_MAX)
                         && (bus_agree || (cnt_q >= WAIT_MAX));

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         state_q <= ADCRM_IDLE;
         cnt_q   <= CNT_ZERO;
      end
      else
      begin
         case (state_q)
            ADCRM_IDLE:
            begin
               cnt_q <= CNT_ZERO;
               // Start only when the previous done has cleared
               if (take)
                  state_q <= ADCRM_SETUP;
            end
            ADCRM_SETUP:
            begin
               // Chip select and channel settle before strobe falls
               if (cnt_q >= SETUP_MAX)
               begin
                  state_q <= ADCRM_WAIT;
                  cnt_q   <= CNT_ZERO;
               end
               else
                  cnt_q <= cnt_q + CNT_ONE;
            end
            ADCRM_WAIT:
            begin
               // Device times coarse and fine phases itself
               if (done_low_q)
               begin
                  state_q <= ADCRM_SETTLE;
                  cnt_q   <= CNT_ZERO;
               end
               else if (cnt_q >= WAIT_MAX)
                  state_q <= ADCRM_END;
               else
                  cnt_q <= cnt_q + CNT_ONE;
            end
            ADCRM_SETTLE:
            begin
               // Wait out data settle before capture
               // Count stops at the wait limit so it cannot wrap
               if (settle_done)
                  state_q <= ADCRM_END;
               else if (cnt_q < WAIT_MAX)
                  cnt_q <= cnt_q + CNT_ONE;
            end
            ADCRM_END:
               state_q <= ADCRM_IDLE;
            default:
               state_q <= ADCRM_IDLE;
         endcase
      end
   end

   // Select leads the strobe so the device never sees an unselected strobe fall
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         CS_N_O <= 1'b1;
      else
         CS_N_O <= !(take || (state_q == ADCRM_SETUP) || (state_q == ADCRM_WAIT) || (state_q == ADCRM_SETTLE));
   end

   // One joined strobe drives both sample/hold and read
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         STROBE_N_O <= 1'b1;
      else
         STROBE_N_O <= !(setup_done || (state_q == ADCRM_WAIT) || (state_q == ADCRM_SETTLE));
   end

   // Channel held steady across the strobe fall
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         CHANNEL_SELECT_BIT0_O <= CHAN_RST[0];
         CHANNEL_SELECT_BIT1_O <= CHAN_RST[1];
      end
      else if (take)
      begin
         CHANNEL_SELECT_BIT0_O <= CHANNEL_I[0];
         CHANNEL_SELECT_BIT1_O <= CHANNEL_I[1];
      end
   end

   // Bus before done is the old result, so capture only after settle
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         RESULT_O       <= DATA_RST;
         RESULT_VALID_O <= 1'b0;
      end
      else
      begin
         RESULT_VALID_O <= settle_done;
         if (settle_done)
            RESULT_O <= bus_s3_q;
      end
   end

   // Limitation: a missing done flag is only reported, the old result stays
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         TIMEOUT_O <= 1'b0;
      else
         TIMEOUT_O <= wait_expired;
   end

   // Busy covers the take cycle so a second start is refused at once
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         BUSY_O <= 1'b0;
      else
         BUSY_O <= take || (state_q != ADCRM_IDLE);
   end

endmodule

/* File: adcrm_host_monitor.sv */
// Assertion checker for the converter host controller
`timescale 1ns/1ps
module adcrm_host_monitor
   import adcrm_pkg::*;
(
   input wire logic              CLK_SYS_I,
   input wire logic              RST_N_I,
   input wire logic              DONE_N_I,
   input wire logic              CS_N_O,
   input wire logic              STROBE_N_O,
   input wire logic              RESULT_VALID_O,
   input wire logic              TIMEOUT_O,
   input wire logic [DATA_W-1:0] RESULT_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);
   property p_cs; !STROBE_N_O |-> !CS_N_O; endproperty
   a_cs: assert property (p_cs) else $error("strobe without select");
   property p_setup; $fell(CS_N_O) |-> STROBE_N_O [*3] ##1 !STROBE_N_O; endproperty
   a_setup: assert property (p_setup) else $error("strobe setup");
   property p_end; $fell(STROBE_N_O) |-> ##[1:700] (RESULT_VALID_O || TIMEOUT_O); endproperty
   a_end: assert property (p_end) else $error("no end");
   property p_settle; RESULT_VALID_O |-> !$past(DONE_N_I, 4); endproperty
   a_settle: assert property (p_settle) else $error("early capture");
   property p_hold; $changed(RESULT_O) |-> RESULT_VALID_O; endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_rel; RESULT_VALID_O |=> CS_N_O && STROBE_N_O; endproperty
   a_rel: assert property (p_rel) else $error("no release");
   property p_low; RESULT_VALID_O |-> !STROBE_N_O; endproperty
   a_low: assert property (p_low) else $error("strobe high");
   property p_tmo; TIMEOUT_O |-> DONE_N_I && !RESULT_VALID_O; endproperty
   a_tmo: assert property (p_tmo) else $error("bad timeout");
   c_conv: cover property (RESULT_VALID_O);
   c_tmo: cover property (TIMEOUT_O);
   c_start: cover property ($fell(STROBE_N_O));
endmodule
bind adcrm_host adcrm_host_monitor u_mon(.CLK_SYS_I, .RST_N_I, .DONE_N_I, .CS_N_O, .STROBE_N_O,
   .RESULT_VALID_O, .TIMEOUT_O, .RESULT_O);

/* File: adcrm_dev_model.sv */
// Behavioural converter model, combined read mode
`timescale 1ns/1ps
module adcrm_dev_model #(
   parameter int DONE_NS = 850
)(
   input  wire logic             cs_n_i,
   input  wire logic             strobe_n_i,
   input  wire logic             sel0_i,
   input  wire logic             sel1_i,
   input  wire logic             mute_i,
   input  wire logic [3:0][9:0]  ain_i,
   output logic                  done_n_o,
   output logic [9:0]            bus_o
);
   logic [9:0] res_q = 10'h000;
   logic [9:0] smp_q = 10'h000;
   initial done_n_o = 1'b1;
   always @(negedge strobe_n_i)
   begin
      if (!cs_n_i)
      begin
         smp_q = ain_i[{sel1_i, sel0_i}]; // One sample per cycle
         #(DONE_NS); // Internal timer
         if (!strobe_n_i && !mute_i)
         begin
            done_n_o = 1'b0;
            #20 res_q = smp_q;
         end
      end
   end
   always @(posedge strobe_n_i) done_n_o = 1'b1;
   // Released bus shows inverse, never a stale word
   assign bus_o = (!cs_n_i && !strobe_n_i) ? res_q : ~res_q;
endmodule

/* File: adcrm_host_tb_top.sv */
// Self-checking bench for the converter host controller
`timescale 1ns/1ps
module adcrm_host_tb_top;
   import adcrm_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, mute = 1'b0;
   logic [CHAN_W-1:0] chan = 2'h0;
   logic [3:0][9:0] ain = '0;
   logic done_n, cs_n, strobe_n, s0, s1, busy, valid, tmo;
   logic [DATA_W-1:0] bus, res;
   int n_errors = 0;
   int check_count = 0;
   always #2.5 clk = ~clk;
   adcrm_host uut(.CLK_SYS_I(clk), .RST_N_I(rst_n), .START_I(start), .CHANNEL_I(chan), .DONE_N_I(done_n),
      .RESULT_BUS_I(bus), .CS_N_O(cs_n), .STROBE_N_O(strobe_n), .CHANNEL_SELECT_BIT0_O(s0),
      .CHANNEL_SELECT_BIT1_O(s1), .BUSY_O(busy), .RESULT_VALID_O(valid), .TIMEOUT_O(tmo), .RESULT_O(res));
   adcrm_dev_model u_dev(.cs_n_i(cs_n), .strobe_n_i(strobe_n), .sel0_i(s0), .sel1_i(s1), .mute_i(mute),
      .ain_i(ain), .done_n_o(done_n), .bus_o(bus));
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Waits for valid or timeout; old word must show mid-conversion
   task automatic run(input logic [9:0] prev);
      int i;
      i = 0;
      start = 1'b1;
      while (valid !== 1'b1 && tmo !== 1'b1 && i < 800)
      begin
         @(posedge clk);
         #1;
         i++;
         if (busy === 1'b1) start = 1'b0;
         if (i == 20 && !mute) check("old word", bus, prev);
         if (i == 20) check("select low", {9'h000, cs_n}, 10'h000);
         if (i == 20) check("strobe low", {9'h000, strobe_n}, 10'h000);
         if (i == 20) check("busy", {9'h000, busy}, 10'h001);
      end
      if (i == 800)
      begin
         n_errors++;
         end_sim;
      end
   endtask
   task automatic s_convert(input logic [1:0] ch, input logic [9:0] code);
      logic [9:0] prev;
      prev = res;
      ain[ch] = code;
      chan = ch;
      run(prev);
      check("result", res, code);
      check("select", {8'h00, s1, s0}, {8'h00, ch});
      @(posedge clk);
      #1;
      check("strobe", {9'h000, strobe_n}, 10'h001);
      check("select released", {9'h000, cs_n}, 10'h001);
      check("valid pulse", {9'h000, valid}, 10'h000);
      repeat (3) @(posedge clk);
      #1;
      check("idle", {9'h000, busy}, 10'h000);
   endtask
   task automatic s_timeout;
      logic [9:0] prev;
      prev = res;
      mute = 1'b1;
      run(prev);
      check("timeout", {9'h000, tmo}, 10'h001);
      check("kept", res, prev);
      mute = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Reset mid-conversion releases the joined strobe and the select and clears the result
   task automatic s_reset;
      repeat (4) @(posedge clk);
      #1;
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      check("busy on take", {9'h000, busy}, 10'h001);
      repeat (20) @(posedge clk);
      #1;
      check("strobe before reset", {9'h000, strobe_n}, 10'h000);
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("reset strobe", {9'h000, strobe_n}, 10'h001);
      check("reset select", {9'h000, cs_n}, 10'h001);
      check("reset busy", {9'h000, busy}, 10'h000);
      check("reset result", res, 10'h000);
      rst_n = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("idle strobe", {9'h000, strobe_n}, 10'h001);
      check("idle busy", {9'h000, busy}, 10'h000);
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      s_convert(2'h0, 10'h000);
      s_convert(2'h1, 10'h3FF);
      s_convert(2'h2, 10'h155);
      s_convert(2'h3, 10'h2AA);
      s_timeout;
      s_convert(2'h3, 10'h0F0);
      s_reset;
      end_sim;
   end
endmodule
